/* File: eumc_core.sv */
`timescale 1ns/100ps
// How it works
// - rx size code picks 5..17 bits
// - tx size code same, 1110 reserved
// - extended enable selects extended or standard mode
// - rx stop select gives one or two
// - tx stop count from base stop control
// - manchester bit selects manchester or level coding, async only
// - mode from sync, manchester, extended bits
// - bit order bit selects lsb or msb
// - frame error flag set, valid until read
// - length flag tells 16 or 17 bits
// - stop values loaded only in manchester
// - 16-bit divisor, two bytes, reset zero
module eumc_core
    import eumc_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [eumc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                    wvalid,
    output logic                         wready,
    input  wire logic [eumc_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]              wstrb,
    output logic                         bvalid,
    input  wire logic                    bready,
    output logic [1:0]                   bresp,
    input  wire logic                    arvalid,
    output logic                         arready,
    input  wire logic [eumc_pkg::ADDR_W-1:0] araddr,
    output logic                         rvalid,
    input  wire logic                    rready,
    output logic [eumc_pkg::DATA_W-1:0]  rdata,
    output logic [1:0]                   rresp,
    input  wire logic                    sync_mode_select,
    input  wire logic                    tx_stop_bit_select,
    input  wire logic                    rx_busy,
    input  wire logic                    rx_frame_done,
    input  wire logic                    rx_frame_error,
    input  wire logic                    rx_len17,
    input  wire logic [1:0]              rx_stop_value,
    input  wire logic                    rx_buffer_read,
    output logic [4:0]                   rx_char_bits,
    output logic [4:0]                   tx_char_bits,
    output logic                         rx_16or17,
    output eumc_pkg::eumc_mode_t         op_mode,
    output logic                         extended_on,
    output logic                         manchester_on,
    output logic                         msb_first,
    output logic                         rx_two_stop,
    output logic                         tx_two_stop,
    output logic [eumc_pkg::DIV_W-1:0]   manchester_divisor,
    output logic                         bit_tick,
    output logic                         mid_tick,
    output logic                         irq
);
    import eumc_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0]        csize;      // character size control
        logic [7:0]        extctl;     // extended mode control
        logic [3:0]        mstat;      // manchester rx status
        logic [DIV_W-1:0]  div;        // manchester divisor
        logic [IRQ_W-1:0]  irq_sts;    // sticky events
        logic [IRQ_W-1:0]  irq_msk;    // event enables
        logic              cfg_bad;    // last reserved-config level
        logic              aw_rdy;
        logic              w_rdy;
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] aw_addr;
        logic [7:0]        w_byte;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              ar_rdy;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [DATA_W-1:0] rdata;
        logic [4:0]        rx_bits;
        logic [4:0]        tx_bits;
        logic              rx_1617;
        eumc_mode_t        mode;
        logic              ext_on;
        logic              man_on;
        logic              msb_first;
        logic              rx_two;
        logic              tx_two;
        logic              irq;
    } eumc_state_t;

    eumc_state_t st_ff;   // registered state
    eumc_state_t nxt_st;  // next state

    logic              ext_now;   // extended mode from control now
    logic              man_now;   // manchester coding active now
    eumc_mode_t        mode_now;  // decoded mode now
    logic              bad_now;   // reserved selection in effect
    logic              aw_take;   // address handshake this cycle
    logic              w_take;    // data handshake this cycle
    logic              do_write;  // both halves present
    logic [ADDR_W-1:0] wr_addr;   // effective write address
    logic [7:0]        wr_byte;   // effective write byte
    logic              wr_lane0;  // low byte lane enabled
    logic [IRQ_W-1:0]  ev;        // event pulses
    logic [IRQ_W-1:0]  w1c;       // bits software clears
    logic [7:0]        rd_val;    // read mux
    logic              rd_hit;    // read address mapped
    logic              wr_hit;    // write address mapped
    logic              cnt_bit;   // counter bit tick
    logic              cnt_mid;   // counter mid tick

    // ****************************************************************
    // mode decode
    // ****************************************************************
    always_comb begin
        ext_now = st_ff.extctl[BIT_EXT_EN];
        // synchronous manchester is reserved, so no coding then
        man_now = ext_now && st_ff.extctl[BIT_MAN_SEL]
                  && !sync_mode_select;
        if (!ext_now) begin
            mode_now = sync_mode_select ? MODE_STD_SYNC
                                        : MODE_STD_ASYNC;
        end else if (!sync_mode_select) begin
            mode_now = st_ff.extctl[BIT_MAN_SEL] ? MODE_EXT_AMAN
                                                 : MODE_EXT_ALVL;
        end else begin
            mode_now = st_ff.extctl[BIT_MAN_SEL] ? MODE_RSVD
                                                 : MODE_EXT_SLVL;
        end
        // reserved codes only matter while extended mode is on
        bad_now = ext_now && ((mode_now == MODE_RSVD)
                  || (eumc_bits(st_ff.csize[7:4]) == BITS_NONE)
                  || ((eumc_bits(st_ff.csize[3:0]) == BITS_NONE)
                      && (st_ff.csize[3:0] != CS_16OR17))
                  || ((st_ff.csize[3:0] == CS_16OR17) && !man_now));
    end

    // ****************************************************************
    // bus handshake helpers
    // ****************************************************************
    always_comb begin
        aw_take  = awvalid && st_ff.aw_rdy;
        w_take   = wvalid && st_ff.w_rdy;
        do_write = (st_ff.aw_got || aw_take) && (st_ff.w_got || w_take)
                   && !st_ff.bvalid;
        wr_addr  = st_ff.aw_got ? st_ff.aw_addr : awaddr;
        wr_byte  = st_ff.w_got ? st_ff.w_byte : wdata[7:0];
        wr_lane0 = st_ff.w_got ? st_ff.w_lane0 : wstrb[0];
        wr_hit   = (wr_addr[1:0] == 2'h0) && (wr_addr <= OFS_IRQ_MSK);
    end

    // ****************************************************************
    // read mux, reserved bits read zero
    // ****************************************************************
    always_comb begin
        rd_hit = 1'b1;
        case (araddr)
            OFS_CSIZE:   rd_val = st_ff.csize;
            OFS_EXTCTL:  rd_val = st_ff.extctl & EXTCTL_WMASK;
            OFS_MSTAT:   rd_val = {4'h0, st_ff.mstat};
            OFS_DIV_HI:  rd_val = st_ff.div[15:8];
            OFS_DIV_LO:  rd_val = st_ff.div[7:0];
            OFS_IRQ_STS: rd_val = {5'h00, st_ff.irq_sts};
            OFS_IRQ_MSK: rd_val = {5'h00, st_ff.irq_msk};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        w1c    = '0;
        // write address and data channels, taken in either order
        if (aw_take) begin
            nxt_st.aw_rdy  = 1'b0;
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = awaddr;
        end
        if (w_take) begin
            nxt_st.w_rdy   = 1'b0;
            nxt_st.w_got   = 1'b1;
            nxt_st.w_byte  = wdata[7:0];
            nxt_st.w_lane0 = wstrb[0];
        end
        if (do_write) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (wr_lane0) begin
                unique case (wr_addr)
                    OFS_CSIZE:   nxt_st.csize = wr_byte;
                    // reserved bits are dropped on write
                    OFS_EXTCTL:  nxt_st.extctl = wr_byte
                                     & EXTCTL_WMASK;
                    OFS_DIV_HI:  nxt_st.div[15:8] = wr_byte;
                    OFS_DIV_LO:  nxt_st.div[7:0] = wr_byte;
                    OFS_IRQ_STS: w1c = wr_byte[IRQ_W-1:0];
                    OFS_IRQ_MSK: nxt_st.irq_msk = wr_byte[IRQ_W-1:0];
                    // status c is hardware owned, writes are ignored
                    default: ;
                endcase
            end
        end
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.aw_rdy = 1'b1;
            nxt_st.w_rdy  = 1'b1;
        end
        // read channel, one read at a time
        if (arvalid && st_ff.ar_rdy) begin
            nxt_st.ar_rdy = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = {24'h000000, rd_val};
            nxt_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.ar_rdy = 1'b1;
        end
        // buffer read ends the validity of the per-frame flags
        if (rx_buffer_read) begin
            nxt_st.mstat[BIT_MAN_FERR] = 1'b0;
            nxt_st.mstat[BIT_LEN17]    = 1'b0;
        end
        // a completed frame wins over a read in the same cycle
        if (rx_frame_done && man_now) begin
            nxt_st.mstat[BIT_MAN_FERR] = rx_frame_error;
            nxt_st.mstat[BIT_LEN17] = (st_ff.csize[3:0] == CS_16OR17)
                                      && rx_len17;
            nxt_st.mstat[1:0] = rx_stop_value;
        end
        // events: set wins over write-one-to-clear
        ev[IRQ_RXDONE] = rx_frame_done;
        ev[IRQ_FERR]   = rx_frame_done && man_now && rx_frame_error;
        ev[IRQ_CFGBAD] = bad_now && !st_ff.cfg_bad;
        nxt_st.cfg_bad = bad_now;
        nxt_st.irq_sts = (st_ff.irq_sts & ~w1c) | ev;
        nxt_st.irq     = |(nxt_st.irq_sts & nxt_st.irq_msk);
        // registered configuration outputs
        nxt_st.ext_on    = ext_now;
        nxt_st.mode      = mode_now;
        nxt_st.man_on    = man_now;
        nxt_st.msb_first = st_ff.extctl[BIT_ORDER];
        nxt_st.rx_two    = ext_now && st_ff.extctl[BIT_RX_STOP];
        nxt_st.tx_two    = tx_stop_bit_select;
        // in standard mode the base usart owns the character size
        nxt_st.rx_1617 = ext_now && man_now
                         && (st_ff.csize[3:0] == CS_16OR17);
        nxt_st.rx_bits = !ext_now ? BITS_NONE
                       : nxt_st.rx_1617 ? 5'h10
                       : eumc_bits(st_ff.csize[3:0]);
        nxt_st.tx_bits = ext_now ? eumc_bits(st_ff.csize[7:4])
                                 : BITS_NONE;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff        <= '0;
            st_ff.csize  <= RST_CSIZE;
            st_ff.extctl <= RST_EXTCTL;
            st_ff.div    <= RST_DIV;
            st_ff.aw_rdy <= 1'b1;
            st_ff.w_rdy  <= 1'b1;
            st_ff.ar_rdy <= 1'b1;
            st_ff.mode   <= MODE_STD_ASYNC;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // manchester bit period counter
    // ****************************************************************
    eumc_baud_cnt #(
        .DIV_W    (DIV_W)
    ) u_baud (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (rx_busy && man_now),
        .max_cnt  (st_ff.div),
        .bit_tick (cnt_bit),
        .mid_tick (cnt_mid)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign awready            = st_ff.aw_rdy;
    assign wready             = st_ff.w_rdy;
    assign bvalid             = st_ff.bvalid;
    assign bresp              = st_ff.bresp;
    assign arready            = st_ff.ar_rdy;
    assign rvalid             = st_ff.rvalid;
    assign rdata              = st_ff.rdata;
    assign rresp              = st_ff.rresp;
    assign rx_char_bits       = st_ff.rx_bits;
    assign tx_char_bits       = st_ff.tx_bits;
    assign rx_16or17          = st_ff.rx_1617;
    assign op_mode            = st_ff.mode;
    assign extended_on        = st_ff.ext_on;
    assign manchester_on      = st_ff.man_on;
    assign msb_first          = st_ff.msb_first;
    assign rx_two_stop        = st_ff.rx_two;
    assign tx_two_stop        = st_ff.tx_two;
    assign manchester_divisor = st_ff.div;
    assign bit_tick           = cnt_bit;
    assign mid_tick           = cnt_mid;
    assign irq                = st_ff.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_rx_size;
        ext_now && st_ff.csize[3:0] == 4'hF |=> rx_char_bits == 5'h11;
    endproperty
    a_rx_size: assert property (p_rx_size)
        else $error("rx size code 1111 not 17 bits");

    property p_tx_rsvd;
        ext_now && st_ff.csize[7:4] == CS_16OR17 |=> tx_char_bits == 5'h00;
    endproperty
    a_tx_rsvd: assert property (p_tx_rsvd)
        else $error("tx size code 1110 not reserved");

    property p_std;
        !ext_now |=> !extended_on && op_mode inside
            {MODE_STD_ASYNC, MODE_STD_SYNC} && !manchester_on;
    endproperty
    a_std: assert property (p_std)
        else $error("standard mode not kept with extended off");

    property p_rx_stop;
        ext_now |=> rx_two_stop == $past(st_ff.extctl[BIT_RX_STOP]);
    endproperty
    a_rx_stop: assert property (p_rx_stop)
        else $error("rx stop count wrong");

    property p_tx_stop;
        ##1 tx_two_stop == $past(tx_stop_bit_select);
    endproperty
    a_tx_stop: assert property (p_tx_stop)
        else $error("tx stop count not from base control");

    property p_sync_man;
        ext_now && st_ff.extctl[BIT_MAN_SEL] && sync_mode_select
            |=> op_mode == MODE_RSVD && !manchester_on;
    endproperty
    a_sync_man: assert property (p_sync_man)
        else $error("synchronous manchester not reserved");

    property p_order;
        ##1 msb_first == $past(st_ff.extctl[BIT_ORDER]);
    endproperty
    a_order: assert property (p_order)
        else $error("bit order does not follow control");

    sequence s_bad_frame;
        rx_frame_done && man_now && rx_frame_error;
    endsequence
    sequence s_kept;
        !rx_buffer_read && !rx_frame_done;
    endsequence
    property p_man_ferr;
        s_bad_frame ##1 s_kept |=> st_ff.mstat[BIT_MAN_FERR];
    endproperty
    a_man_ferr: assert property (p_man_ferr)
        else $error("frame error flag lost before buffer read");

    property p_len;
        rx_frame_done && man_now && st_ff.csize[3:0] == CS_16OR17
            |=> st_ff.mstat[BIT_LEN17] == $past(rx_len17);
    endproperty
    a_len: assert property (p_len)
        else $error("length flag does not match frame");

    property p_stop_hold;
        !man_now |=> $stable(st_ff.mstat[1:0]);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stop values changed in level mode");

endmodule

/* File: eumc_pkg.sv */
// ****************************************************************
// shared constants for the extended usart configuration block
// ****************************************************************
package eumc_pkg;

    localparam int          ADDR_W       = 8;   // axi address width
    localparam int          DATA_W       = 32;  // axi data width
    localparam int          DIV_W        = 16;  // manchester divisor width

    // register byte offsets
    localparam logic [7:0]  OFS_CSIZE    = 8'h00;
    localparam logic [7:0]  OFS_EXTCTL   = 8'h04;
    localparam logic [7:0]  OFS_MSTAT    = 8'h08;
    localparam logic [7:0]  OFS_DIV_HI   = 8'h0C;
    localparam logic [7:0]  OFS_DIV_LO   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_STS  = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MSK  = 8'h18;

    // reset values
    localparam logic [7:0]  RST_CSIZE    = 8'h33;
    localparam logic [7:0]  RST_EXTCTL   = 8'h00;
    localparam logic [15:0] RST_DIV      = 16'h0000;

    // control register b: writable bits and positions
    localparam logic [7:0]  EXTCTL_WMASK = 8'h1B;
    localparam int          BIT_EXT_EN   = 4;
    localparam int          BIT_RX_STOP  = 3;
    localparam int          BIT_MAN_SEL  = 1;
    localparam int          BIT_ORDER    = 0;

    // status register c bit positions
    localparam int          BIT_MAN_FERR = 3;
    localparam int          BIT_LEN17    = 2;

    // interrupt status bit positions
    localparam int          IRQ_W        = 3;
    localparam int          IRQ_RXDONE   = 0;
    localparam int          IRQ_FERR     = 1;
    localparam int          IRQ_CFGBAD   = 2;

    // character size codes
    localparam logic [3:0]  CS_16OR17    = 4'hE;
    localparam logic [4:0]  BITS_NONE    = 5'h00;

    // axi responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // operating modes, gray coded along the usual sequence
    typedef enum logic [2:0] {
        MODE_STD_ASYNC = 3'h0,
        MODE_STD_SYNC  = 3'h1,
        MODE_EXT_ALVL  = 3'h3,
        MODE_EXT_AMAN  = 3'h2,
        MODE_EXT_SLVL  = 3'h6,
        MODE_RSVD      = 3'h7
    } eumc_mode_t;

    // character size code to data bit count, zero for reserved codes
    function automatic logic [4:0] eumc_bits(input logic [3:0] code);
        logic [4:0] n;
        n = BITS_NONE;
        case (code)
            4'h0: n = 5'h05;
            4'h1: n = 5'h06;
            4'h2: n = 5'h07;
            4'h3: n = 5'h08;
            4'h7: n = 5'h09;
            4'h8: n = 5'h0D;
            4'h9: n = 5'h0E;
            4'hA: n = 5'h0F;
            4'hB: n = 5'h10;
            4'hF: n = 5'h11;
            default: n = BITS_NONE;
        endcase
        return n;
    endfunction

endpackage

/* File: eumc_baud_cnt.sv */
`timescale 1ns/100ps
// ****************************************************************
// manchester receiver bit period counter
// ****************************************************************
module eumc_baud_cnt #(
    parameter int DIV_W = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] max_cnt,
    output logic                  bit_tick,
    output logic                  mid_tick
);

    // whole state of the counter
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             bit_tick;
        logic             mid_tick;
    } eumc_cnt_t;

    eumc_cnt_t cnt_ff;   // registered state
    eumc_cnt_t nxt_cnt;  // next state

    // ****************************************************************
    // counting
    // ****************************************************************
    // the live divisor is used; changing it mid-frame skews the frame
    always_comb begin
        nxt_cnt          = cnt_ff;
        nxt_cnt.bit_tick = 1'b0;
        nxt_cnt.mid_tick = 1'b0;
        if (!run) begin
            nxt_cnt.cnt = '0;
        end else if (cnt_ff.cnt >= max_cnt) begin
            nxt_cnt.cnt      = '0;
            nxt_cnt.bit_tick = 1'b1;
        end else begin
            nxt_cnt.cnt      = cnt_ff.cnt + 1'b1;
            nxt_cnt.mid_tick = (cnt_ff.cnt == (max_cnt >> 1));
        end
    end

    // register the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign bit_tick = cnt_ff.bit_tick;
    assign mid_tick = cnt_ff.mid_tick;

    // a full period ends with exactly one bit tick
    property p_period;
        @(posedge aclk) disable iff (!aresetn)
        run && cnt_ff.cnt >= max_cnt |=> bit_tick && cnt_ff.cnt == '0;
    endproperty
    a_period: assert property (p_period)
        else $error("bit period did not end at the divisor");

endmodule

/* File: eumc_node.sv */
`timescale 1ns/100ps
// ****************************************************************
// remote serial node: frames after go
// ****************************************************************
module eumc_node (
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic       err,
    input  wire logic       l17,
    input  wire logic [1:0] sv,
    output logic            rx_busy,
    output logic            rx_frame_done,
    output logic            rx_frame_error,
    output logic            rx_len17,
    output logic [1:0]      rx_stop_value
);
    logic [1:0] cnt_ff = 2'h0; // cycles left in the frame
    // short frame; the divisor stays put meanwhile
    always_ff @(posedge aclk) begin
        cnt_ff <= go ? 2'h3 : (cnt_ff != 2'h0 ? cnt_ff - 2'h1 : 2'h0);
    end
    assign rx_busy        = cnt_ff != 2'h0;
    assign rx_frame_done  = cnt_ff == 2'h1;
    // qualifiers are garbage outside the done pulse
    assign rx_frame_error = rx_frame_done ? err : ~err;
    assign rx_len17       = rx_frame_done ? l17 : ~l17;
    assign rx_stop_value  = rx_frame_done ? sv : ~sv;
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    import eumc_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, sync_mode_select = 0;
    logic tx_stop_bit_select = 0, rx_buffer_read = 0, go = 0, err = 0;
    logic l17 = 0, awready, wready, bvalid, arready, rvalid, rx_16or17;
    logic rx_busy, rx_frame_done, rx_frame_error, rx_len17, extended_on;
    logic manchester_on, msb_first, rx_two_stop, tx_two_stop, irq;
    logic bit_tick, mid_tick;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] sv = 2'h0, bresp, rresp, rx_stop_value;
    logic [4:0] rx_char_bits, tx_char_bits;
    logic [15:0] manchester_divisor;
    eumc_mode_t op_mode;
    logic [31:0] rd;
    logic [1:0] rs;
    int bad_count = 0, checks_done = 0;
    logic [4:0] xb [16] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h00, 5'h00,
        5'h00, 5'h09, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h00, 5'h00, 5'h10, 5'h11};
    logic [2:0] md [8] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7};
    eumc_core eumc_core_inst (.*);
    eumc_node eumc_node_inst (.*);
    initial begin
        forever #20 aclk = ~aclk;
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    // write one register, wait for the response
    // called just after a rising edge; returns just after a rising edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic ah, wh, fin;
        fin = 1'b0;
        awvalid <= 1;
        wvalid <= 1;
        awaddr <= a;
        wdata <= {24'h0, d};
        bready <= 1;
        // only the watchdog ends a wait whose answer never comes
        while (!fin) begin
            @(negedge aclk);
            ah = awready;
            wh = wready;
            rs = bresp;
            fin = bvalid === 1'b1;
            @(posedge aclk);
            if (ah) awvalid <= 0;
            if (wh) wvalid <= 0;
        end
        bready <= 0;
        @(posedge aclk);
    endtask
    task rdr(input logic [7:0] a);
        logic ah, fin;
        fin = 1'b0;
        arvalid <= 1;
        araddr <= a;
        rready <= 1;
        while (!fin) begin
            @(negedge aclk);
            ah = arready;
            rd = rdata;
            rs = rresp;
            fin = rvalid === 1'b1;
            @(posedge aclk);
            if (ah) arvalid <= 0;
        end
        rready <= 0;
        @(posedge aclk);
    endtask
    task frame(input logic e, input logic [1:0] s, input logic [7:0] t);
        logic [7:0] nb, nm;
        nb = 8'h00;
        nm = 8'h00;
        go <= 1;
        err <= e;
        l17 <= 1;
        sv <= s;
        @(posedge aclk) go <= 0;
        // count tick pulses mid-cycle while the frame runs
        repeat (6) begin
            @(negedge aclk);
            nb = nb + bit_tick;
            nm = nm + mid_tick;
        end
        @(posedge aclk);
        chk("ticks", {nb, nm}, {t, t});
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        results();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        rdr(OFS_CSIZE);
        chk("size", rd, 32'h33);
        rdr(OFS_DIV_HI);
        chk("divh", rd, 32'h0);
        rdr(8'h1C);
        chk("unmapped", rs, RESP_SLVERR);
        tx_stop_bit_select <= 1;
        wr(OFS_EXTCTL, 8'hFF);
        rdr(OFS_EXTCTL);
        chk("ctlb", rd, 32'h1B);
        chk("flags", {extended_on, manchester_on, msb_first, rx_two_stop,
            tx_two_stop}, 32'h1F);
        for (int i = 0; i < 16; i++) begin
            wr(OFS_CSIZE, {i[3:0], i[3:0]});
            chk("rxbits", rx_char_bits, xb[i]);
            chk("txbits", tx_char_bits, i == 14 ? 5'h0 : xb[i]);
        end
        for (int i = 0; i < 8; i++) begin
            sync_mode_select <= i[1];
            wr(OFS_EXTCTL, {3'h0, i[2], 2'h0, i[0], 1'b0});
            chk("mode", op_mode, md[i]);
        end
        sync_mode_select <= 0;
        // manchester is entered before the 16-or-17 size code is written
        wr(OFS_EXTCTL, 8'h12);
        wr(OFS_CSIZE, 8'hFE);
        chk("r1617", rx_16or17, 1'b1);
        wr(OFS_DIV_LO, 8'h02);
        wr(OFS_IRQ_MSK, 8'h03);
        wr(OFS_IRQ_STS, 8'h07);
        frame(1, 2'h2, 8'h01);
        rdr(OFS_MSTAT);
        chk("stat", rd, 32'h0E);
        chk("irq", irq, 1'b1);
        rx_buffer_read <= 1;
        @(posedge aclk) rx_buffer_read <= 0;
        rdr(OFS_MSTAT);
        chk("cleared", rd, 32'h02);
        wr(OFS_IRQ_STS, 8'h07);
        chk("irqclr", irq, 1'b0);
        wr(OFS_EXTCTL, 8'h10);
        wr(OFS_MSTAT, 8'h00);
        chk("wresp", rs, RESP_OKAY);
        wr(8'h1C, 8'h55);
        chk("wunmap", rs, RESP_SLVERR);
        frame(0, 2'h1, 8'h00);
        rdr(OFS_MSTAT);
        chk("lvl", rd, 32'h02);
        wr(OFS_DIV_HI, 8'hAB);
        wr(OFS_DIV_LO, 8'hCD);
        chk("div", manchester_divisor, 16'hABCD);
        results();
    end
endmodule
